/* File: test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Timer A control bench
// ****************************************************************
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module testbench;
  import tmra_pkg::*;
  logic                   clk;
  logic                   nrst;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [TMRA_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  tmra_byte_t             match_value;
  logic                   ext_pin;
  logic                   cap_pin;
  logic                   tog_out;
  logic                   irq;
  logic [31:0]            rdat;
  logic                   err;
  int                     error_cnt;
  int                     compares;
  int                     c0;
  int                     e;
  int                     k;
  int                     hi;

  tmra_timer tmra_timer_inst (
    .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MATCH_VALUE(match_value),
    .EXTERNAL_COUNT_CLOCK_PIN(ext_pin), .CAPTURE_PIN(cap_pin),
    .INTERVAL_TOGGLE_OUTPUT(tog_out), .IRQ(irq)
  );

  always #20 clk = ~clk;

  // ****************************************************************
  // Bus and helpers
  // ****************************************************************
  // Request held until pready is seen high; read data taken at that edge
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      final_report();
    end
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Model of the control readback: clear reads 0, pending from model
  function automatic int ctrl_exp(input int wv, input int pend);
    return (wv & 'hDC) | pend;
  endfunction

  task automatic final_report();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    error_cnt++;
    final_report();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; match_value = 8'h80; ext_pin = 0; cap_pin = 0;
    error_cnt = 0; compares = 0;
    void'($urandom(6252));
    tick(10);
    nrst <= 1'b1;
    tick(1);
    apb(0, TMRA_IDX_CTRL, 0);
    `CHK("ctrl reset", 32'h00, rdat)
    apb(0, TMRA_IDX_DIV, 0);
    `CHK("div reset", 32'h00, rdat)
    for (k = 0; k < 4; k++) begin
      apb(1, TMRA_IDX_CTRL, k << 6 | 'h2C);
      apb(0, TMRA_IDX_CTRL, 0);
      `CHK("mode field", ctrl_exp(k << 6 | 'h0C, 0), rdat)
    end
    $display("test registers done");
    // Counts hold still while stopped
    apb(0, TMRA_IDX_COUNT, 0);
    c0 = rdat;
    tick(20);
    apb(0, TMRA_IDX_COUNT, 0);
    `CHK("stopped count", 32'h0, rdat)
    // Internal source divided by 2^e over a 259 cycle read interval
    e = $urandom_range(0, 3);
    apb(1, TMRA_IDX_DIV, e);
    apb(1, TMRA_IDX_CTRL, 'h70);
    apb(0, TMRA_IDX_COUNT, 0);
    c0 = rdat;
    tick(256);
    apb(0, TMRA_IDX_COUNT, 0);
    k = (rdat - c0) & 'hFF;
    `CHK("prescale", 1, (((k - (259 >> e) + 1) & 'hFF) <= 2))
    $display("test prescale done");
    // External pin: no ticks while pin idle, one per rising edge
    apb(1, TMRA_IDX_CTRL, 'h60);
    apb(1, TMRA_IDX_DIV, 'h80);
    apb(1, TMRA_IDX_CTRL, 'h50);
    tick(20);
    apb(0, TMRA_IDX_COUNT, 0);
    `CHK("ext idle", 32'h0, rdat)
    k = $urandom_range(3, 9);
    repeat (k) begin
      ext_pin <= 1'b1;
      tick(4);
      ext_pin <= 1'b0;
      tick(4);
    end
    tick(6);
    apb(0, TMRA_IDX_COUNT, 0);
    `CHK("ext count", k, rdat)
    $display("test external done");
    // Overflow, mask and clear paths
    apb(1, TMRA_IDX_IMASK, 1);
    apb(1, TMRA_IDX_DIV, 0);
    apb(1, TMRA_IDX_CTRL, 'h74);
    tick(270);
    apb(0, TMRA_IDX_CTRL, 0);
    `CHK("ovf pend", ctrl_exp('h54, 1), rdat)
    `CHK("irq set", 1'b1, irq)
    apb(1, TMRA_IDX_CTRL, 'h45);
    apb(0, TMRA_IDX_COUNT, 0);
    c0 = rdat;
    apb(0, TMRA_IDX_CTRL, 0);
    `CHK("pend w1 keeps", ctrl_exp('h44, 1), rdat)
    apb(1, TMRA_IDX_CTRL, 'h44);
    apb(0, TMRA_IDX_CTRL, 0);
    `CHK("pend w0 clears", ctrl_exp('h44, 0), rdat)
    apb(1, TMRA_IDX_IMASK, 0);
    `CHK("irq masked", 1'b0, irq)
    apb(1, TMRA_IDX_IMASK, 1);
    `CHK("irq unmasked", 1'b1, irq)
    apb(1, TMRA_IDX_ISTAT, 1);
    `CHK("irq cleared", 1'b0, irq)
    apb(0, TMRA_IDX_COUNT, 0);
    `CHK("clear zero no effect", c0, rdat)
    apb(1, TMRA_IDX_CTRL, 'h64);
    apb(0, TMRA_IDX_COUNT, 0);
    `CHK("clear one zeroes", 32'h0, rdat)
    $display("test overflow done");
    // Capture modes: the wrong edge leaves pending clear
    for (k = 1; k < 3; k++) begin
      cap_pin <= (k == 1);
      apb(1, TMRA_IDX_CTRL, k << 6 | 'h30);
      tick(8);
      apb(1, TMRA_IDX_CTRL, k << 6 | 'h10);
      cap_pin <= ~cap_pin;
      tick(8);
      apb(0, TMRA_IDX_CTRL, 0);
      `CHK("capture wrong edge", 0, rdat[1])
      cap_pin <= ~cap_pin;
      tick(8);
      apb(0, TMRA_IDX_CTRL, 0);
      `CHK("capture edge", 1, rdat[1])
    end
    $display("test capture done");
    // Interval: match restarts counter, no overflow
    match_value <= 8'($urandom_range(4, 20));
    apb(1, TMRA_IDX_CTRL, 'h20);
    apb(1, TMRA_IDX_CTRL, 'h10);
    tick(60);
    apb(1, TMRA_IDX_CTRL, 'h03);
    apb(0, TMRA_IDX_CTRL, 0);
    `CHK("interval flags", 32'h02, rdat)
    apb(0, TMRA_IDX_COUNT, 0);
    `CHK("interval bound", 1, (rdat <= match_value))
    // PWM duty follows the compare value
    match_value <= 8'h80;
    apb(1, TMRA_IDX_CTRL, 'hE0);
    apb(1, TMRA_IDX_CTRL, 'hD0);
    hi = 0;
    repeat (512) begin
      @(posedge clk);
      hi += (tog_out === 1'b1);
    end
    `CHK("pwm duty", 1, (hi >= 252 && hi <= 260))
    $display("test modes done");
    apb(0, 10'h0E8, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rdat)
    $display("test unmapped done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: verilog/tmra_pkg.sv */
`default_nettype none
package tmra_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int TMRA_ADDR_W = 12;
  localparam int TMRA_DATA_W = 32;
  localparam int TMRA_DIV_W  = 4;
  localparam int TMRA_PRE_W  = 12;

  typedef logic [7:0] tmra_byte_t;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] TMRA_IDX_CTRL  = 10'h0E2;
  localparam logic [9:0] TMRA_IDX_DIV   = 10'h0E3;
  localparam logic [9:0] TMRA_IDX_ISTAT = 10'h0E4;
  localparam logic [9:0] TMRA_IDX_IMASK = 10'h0E5;
  localparam logic [9:0] TMRA_IDX_COUNT = 10'h0E6;
  localparam logic [9:0] TMRA_IDX_CAPT  = 10'h0E7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TMRA_DIV_SRC_BIT = 7;
  localparam int TMRA_EV_OVF      = 0;
  localparam int TMRA_EV_MATCH    = 1;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam tmra_byte_t       TMRA_CTRL_RST = 8'h00;
  localparam tmra_byte_t       TMRA_DIV_RST  = 8'h00;
  localparam logic [1:0]       TMRA_EV_RST   = 2'h0;
  localparam tmra_byte_t       TMRA_CNT_MAX  = 8'hFF;
  localparam logic [3:0]       TMRA_DIV_MAX  = 4'hC;

  // ****************************************************************
  // Modes and control layout
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_INTERVAL,
    MODE_CAP_RISE,
    MODE_CAP_FALL,
    MODE_PWM
  } tmra_mode_t;

  typedef struct packed {
    tmra_mode_t mode;
    logic       clr;
    logic       run;
    logic       match_ie;
    logic       ovf_ie;
    logic       match_pend;
    logic       ovf_pend;
  } tmra_ctrl_t;

endpackage
`default_nettype wire

/* File: verilog/tmra_prescale.sv */
`timescale 1ns/10ps
`default_nettype none
module tmra_prescale #(
  parameter int PRE_W = tmra_pkg::TMRA_PRE_W
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       src_tick,
  input  wire logic [3:0] div_exp,
  output logic            out_tick
);
  import tmra_pkg::*;

  logic [PRE_W-1:0] pre_reg;
  logic [3:0]       exp_lim;
  logic [PRE_W-1:0] pre_mask;

  // Invalid exponents above the limit are held at the limit
  assign exp_lim  = (div_exp > TMRA_DIV_MAX) ? TMRA_DIV_MAX : div_exp;
  assign pre_mask = PRE_W'((PRE_W+1)'(1) << exp_lim) - PRE_W'(1);
  assign out_tick = src_tick && ((pre_reg & pre_mask) == pre_mask);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else if (src_tick) begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

endmodule
`default_nettype wire

/* File: verilog/tmra_timer.sv */
// Overview of operation
// - Counter runs while the run bit is one; run bit resets to zero.
// - Overflow sets its pending flag; writing zero clears it; reads show it.
// - Clock select zero feeds the prescaler from the internal clock.
// - Clock select one takes count clock from the external pin.
`timescale 1ns/10ps
`default_nettype none
module tmra_timer (
  // Clock and reset
  input  wire logic                            CLK,
  input  wire logic                            NRST,
  // APB slave
  input  wire logic                            PSEL,
  input  wire logic                            PENABLE,
  input  wire logic                            PWRITE,
  input  wire logic [tmra_pkg::TMRA_ADDR_W-1:0] PADDR,
  input  wire logic [tmra_pkg::TMRA_DATA_W-1:0] PWDATA,
  output logic      [tmra_pkg::TMRA_DATA_W-1:0] PRDATA,
  output logic                                 PREADY,
  output logic                                 PSLVERR,
  // Compare value from the datapath
  input  wire tmra_pkg::tmra_byte_t            MATCH_VALUE,
  // Pins
  input  wire logic                            EXTERNAL_COUNT_CLOCK_PIN,
  input  wire logic                            CAPTURE_PIN,
  output logic                                 INTERVAL_TOGGLE_OUTPUT,
  // Interrupt
  output logic                                 IRQ
);
  import tmra_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  tmra_ctrl_t   ctrl_reg;
  tmra_byte_t   div_reg;
  logic [1:0]   istat_reg;
  logic [1:0]   imask_reg;
  tmra_byte_t   cnt_reg;
  tmra_byte_t   cnt_next;
  tmra_byte_t   capt_reg;
  logic         out_reg;
  logic [31:0]  prdata_reg;
  logic [2:0]   ext_sync;
  logic [2:0]   cap_sync;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [9:0] idx     = PADDR[TMRA_ADDR_W-1:2];
  wire       aligned = (PADDR[1:0] == 2'h0);
  wire       hit_ctrl  = aligned && (idx == TMRA_IDX_CTRL);
  wire       hit_div   = aligned && (idx == TMRA_IDX_DIV);
  wire       hit_istat = aligned && (idx == TMRA_IDX_ISTAT);
  wire       hit_imask = aligned && (idx == TMRA_IDX_IMASK);
  wire       hit_count = aligned && (idx == TMRA_IDX_COUNT);
  wire       hit_capt  = aligned && (idx == TMRA_IDX_CAPT);
  wire       hit_any   = hit_ctrl | hit_div | hit_istat | hit_imask
                       | hit_count | hit_capt;
  wire       access    = PSEL && PENABLE;
  wire       setup     = PSEL && !PENABLE;
  wire       wr_en     = access && PWRITE && hit_any;
  wire       wr_ctrl   = wr_en && hit_ctrl;
  wire       wr_div    = wr_en && hit_div;
  wire       wr_istat  = wr_en && hit_istat;
  wire       wr_imask  = wr_en && hit_imask;
  wire [7:0] wbyte     = PWDATA[7:0];

  // Read data is latched in the setup phase so the access phase
  // can complete with no wait state
  wire [7:0] rd_byte =
      hit_ctrl  ? 8'(ctrl_reg) :
      hit_div   ? (div_reg & 8'h8F) :
      hit_istat ? {6'h00, istat_reg} :
      hit_imask ? {6'h00, imask_reg} :
      hit_count ? cnt_reg :
      hit_capt  ? capt_reg : 8'h00;

  assign PREADY  = 1'b1;
  assign PSLVERR = access && !hit_any;
  assign PRDATA  = prdata_reg;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ext_sync <= 3'h0;
      cap_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], EXTERNAL_COUNT_CLOCK_PIN};
      cap_sync <= {cap_sync[1:0], CAPTURE_PIN};
    end
  end

  wire ext_rise = ext_sync[1] && !ext_sync[2];
  wire cap_rise = cap_sync[1] && !cap_sync[2];
  wire cap_fall = !cap_sync[1] && cap_sync[2];

  // ****************************************************************
  // Clock source and prescaler
  // ****************************************************************
  wire       ext_sel  = div_reg[TMRA_DIV_SRC_BIT];
  // External counting is limited to half the system clock rate
  wire       src_tick = ext_sel ? ext_rise : 1'b1;
  wire       cnt_tick;

  tmra_prescale #(
    .PRE_W (TMRA_PRE_W)
  ) u_pre (
    .clk      (CLK),
    .nrst     (NRST),
    .src_tick (src_tick),
    .div_exp  (div_reg[TMRA_DIV_W-1:0]),
    .out_tick (cnt_tick)
  );

  // ****************************************************************
  // Counter and mode logic
  // ****************************************************************
  wire clr_req   = wr_ctrl && wbyte[5];
  wire run       = ctrl_reg.run;
  wire is_cap    = (ctrl_reg.mode == MODE_CAP_RISE)
                || (ctrl_reg.mode == MODE_CAP_FALL);
  wire step      = run && cnt_tick && !clr_req;
  wire at_match  = (cnt_reg == MATCH_VALUE);
  wire intv_hit  = step && (ctrl_reg.mode == MODE_INTERVAL) && at_match;
  wire ovf_evt   = step && !intv_hit && (cnt_reg == TMRA_CNT_MAX);
  wire cap_edge  = (ctrl_reg.mode == MODE_CAP_RISE) ? cap_rise : cap_fall;
  wire cap_evt   = run && is_cap && cap_edge;
  wire match_evt = step && !is_cap && at_match;
  wire mc_evt    = match_evt || cap_evt;

  always_comb begin
    cnt_next = cnt_reg;
    if (clr_req) begin
      cnt_next = 8'h00;
    end else if (intv_hit) begin
      cnt_next = 8'h00;
    end else if (step) begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cnt_reg  <= 8'h00;
      capt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
      if (cap_evt) begin
        capt_reg <= cnt_reg;
      end
    end
  end

  // Interval toggles at each match; PWM is high below the match value
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      out_reg <= 1'b0;
    end else begin
      unique case (ctrl_reg.mode)
        MODE_INTERVAL: begin
          if (intv_hit) begin
            out_reg <= !out_reg;
          end
        end
        MODE_PWM: begin
          out_reg <= (cnt_next < MATCH_VALUE);
        end
        MODE_CAP_RISE, MODE_CAP_FALL: begin
          out_reg <= 1'b0;
        end
      endcase
    end
  end

  assign INTERVAL_TOGGLE_OUTPUT = out_reg;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Pending flags: a set in the same cycle beats a software clear
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctrl_reg <= tmra_ctrl_t'(TMRA_CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.mode     <= tmra_mode_t'(wbyte[7:6]);
        ctrl_reg.run      <= wbyte[4];
        ctrl_reg.match_ie <= wbyte[3];
        ctrl_reg.ovf_ie   <= wbyte[2];
      end
      ctrl_reg.clr <= 1'b0;
      ctrl_reg.ovf_pend <= ovf_evt
          || (ctrl_reg.ovf_pend && !(wr_ctrl && !wbyte[0]));
      ctrl_reg.match_pend <= mc_evt
          || (ctrl_reg.match_pend && !(wr_ctrl && !wbyte[1]));
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      div_reg <= TMRA_DIV_RST;
    end else if (wr_div) begin
      div_reg <= wbyte & 8'h8F;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  wire [1:0] ev_vec  = {mc_evt, ovf_evt};
  wire [1:0] ie_vec  = {ctrl_reg.match_ie, ctrl_reg.ovf_ie};
  wire [1:0] w1c_vec = wr_istat ? wbyte[1:0] : 2'h0;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      istat_reg <= TMRA_EV_RST;
      imask_reg <= TMRA_EV_RST;
    end else begin
      istat_reg <= ev_vec | (istat_reg & ~w1c_vec);
      if (wr_imask) begin
        imask_reg <= wbyte[1:0];
      end
    end
  end

  // Enable bits gate the interrupt too, so either layer can silence it
  assign IRQ = |(istat_reg & imask_reg & ie_vec);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_ext_edge;
    ext_sel && ext_sync[1] && !ext_sync[2];
  endsequence

  sequence s_ovf_then_clear;
    ctrl_reg.ovf_pend ##1 (wr_ctrl && !wbyte[0] && !ovf_evt);
  endsequence

  a_run_halts: assert property (@(posedge CLK) disable iff (!NRST)
    (!run && !clr_req) |=> $stable(cnt_reg))
    else $error("counter moved while stopped");

  a_run_counts: assert property (@(posedge CLK) disable iff (!NRST)
    (run && cnt_tick && !clr_req && ctrl_reg.mode == MODE_CAP_RISE)
    |=> cnt_reg == 8'($past(cnt_reg) + 8'h01))
    else $error("counter did not step while running");

  a_ovf_pending: assert property (@(posedge CLK) disable iff (!NRST)
    ovf_evt |=> ctrl_reg.ovf_pend ##1 (ctrl_reg.ovf_pend || $past(wr_ctrl)))
    else $error("overflow pending flag not set");

  a_ovf_clear: assert property (@(posedge CLK) disable iff (!NRST)
    s_ovf_then_clear |=> !ctrl_reg.ovf_pend)
    else $error("overflow pending flag not cleared by zero write");

  a_int_source: assert property (@(posedge CLK) disable iff (!NRST)
    (!ext_sel && div_reg[3:0] == 4'h0) |-> cnt_tick)
    else $error("internal source does not tick every cycle");

  a_ext_source: assert property (@(posedge CLK) disable iff (!NRST)
    (ext_sel && !(ext_sync[1] && !ext_sync[2])) |-> !cnt_tick)
    else $error("external source ticked without a pin edge");

  a_ext_edge_tick: assert property (@(posedge CLK) disable iff (!NRST)
    s_ext_edge and (div_reg[3:0] == 4'h0) |-> cnt_tick)
    else $error("undivided external edge gave no count tick");

  a_clear_zero: assert property (@(posedge CLK) disable iff (!NRST)
    clr_req |=> (cnt_reg == 8'h00) && !ctrl_reg.clr)
    else $error("counter not zero after clear write");

  a_intv_toggle: assert property (@(posedge CLK) disable iff (!NRST)
    intv_hit |=> (out_reg != $past(out_reg)) && cnt_reg == 8'h00)
    else $error("interval match did not toggle output");

  a_capture_latch: assert property (@(posedge CLK) disable iff (!NRST)
    cap_evt |=> ctrl_reg.match_pend && (capt_reg == $past(cnt_reg)))
    else $error("capture edge did not latch the count");

  a_pwm_level: assert property (@(posedge CLK) disable iff (!NRST)
    (ctrl_reg.mode == MODE_PWM) |=> out_reg == ($past(cnt_next) < $past(MATCH_VALUE)))
    else $error("PWM output level wrong");

  a_ovf_wrap: assert property (@(posedge CLK) disable iff (!NRST)
    ovf_evt |=> (cnt_reg == 8'h00) && istat_reg[0])
    else $error("overflow did not wrap and flag status");

  a_pend_sticky: assert property (@(posedge CLK) disable iff (!NRST)
    (ctrl_reg.ovf_pend && !wr_ctrl) |=> ctrl_reg.ovf_pend)
    else $error("overflow pending flag lost without a write");

endmodule
`default_nettype wire
